// [verilog/rf_xfer_pkg.sv]
// constants, carriers and state layout for the rf/audio transfer remote control block
// assumes a 125 MHz hclk and an ahb-lite master issuing single word transfers
package rf_xfer_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_TIME_NS  = 1000000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int TICK_W        = 17;
  localparam int MIN_PULSE_MS  = 250;
  localparam logic [7:0] QUAL_MS_RST = 8'h14;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] QUAL_OFS      = 8'h04;
  localparam logic [7:0] STATUS_OFS    = 8'h08;
  localparam logic [7:0] AUDIO_CMD_OFS = 8'h0C;
  localparam int CTRL_REMOTE_BIT = 0;

  // audio command codes from software or the transmitter serial link
  localparam logic [1:0] ACMD_AUTO   = 2'h1;
  localparam logic [1:0] ACMD_MAIN   = 2'h2;
  localparam logic [1:0] ACMD_BACKUP = 2'h3;

  // remote input indices
  localparam int N_IN   = 9;
  localparam int I_ON   = 0;
  localparam int I_OFF  = 1;
  localparam int I_TX1  = 2;
  localparam int I_TX2  = 3;
  localparam int I_ARF  = 4;
  localparam int I_AAUD = 5;
  localparam int I_MAUD = 6;
  localparam int I_BAUD = 7;
  localparam int I_MNT  = 8;

  // remote inputs, all active low, in index order
  typedef struct packed {
    logic maintenance_request_n;
    logic backup_audio_request_n;
    logic main_audio_request_n;
    logic automatic_audio_transfer_request_n;
    logic automatic_rf_transfer_request_n;
    logic second_transmitter_on_air_request_n;
    logic first_transmitter_on_air_request_n;
    logic rf_disable_request_n;
    logic rf_enable_request_n;
  } remote_n_t;

  typedef struct packed {
    logic interlock_closed;
    logic switch_indicates_position_two;
    logic switch_indicates_position_one;
  } coax_in_t;

  typedef struct packed {
    logic pos_two_drive;
    logic pos_one_drive;
  } coax_out_t;

  typedef struct packed {
    logic second_transmitter_rf_en;
    logic first_transmitter_rf_en;
  } rf_en_t;

  // indicator and status bits, also the low bits of the status register
  typedef struct packed {
    logic remote_enabled;
    logic maintenance;
    logic audio_backup;
    logic auto_audio;
    logic auto_rf;
    logic second_transmitter_main;
    logic first_transmitter_main;
    logic rf_enable_request;
  } status_t;

  typedef struct packed {
    logic [N_IN-1:0]        s1;
    logic [N_IN-1:0]        s2;
    logic [N_IN-1:0]        s3;
    logic [N_IN-1:0]        flt;
    logic [N_IN-1:0]        lvl;
    logic [N_IN-1:0][7:0]   cnt;
    logic [TICK_W-1:0]      tick_cnt;
    logic [2:0]             c1;
    logic [2:0]             c2;
    logic [2:0]             c3;
    logic [2:0]             cflt;
    logic                   rf_enable_request;
    logic                   main_two;
    logic                   auto_rf;
    logic                   auto_audio;
    logic                   audio_backup;
    logic                   maint;
    logic                   cmd_two;
    logic                   remote_en;
    logic [7:0]             qual;
    logic                   a_valid;
    logic                   a_write;
    logic [7:0]             a_addr;
    logic [31:0]            hrdata;
    logic                   rf1;
    logic                   rf2;
  } state_t;
endpackage

// [verilog/rf_xfer_ctrl.sv]
// remote control logic of a main/standby transfer controller with coax switch drive
// assumes remote and coax contact inputs arrive asynchronously; ahb-lite single slave
//
// Summary of operation
// [RQ1] remote inputs ignored unless remote operation is selected
// [RQ2] each input acts once per qualified active pulse, not on level
// [RQ3] remote system should hold each pulse at least 250 ms
// [RQ4] rf_enable_request request enables on-air transmitter rf and lights rf_enable_request
// [RQ5] rf_disable_request request disables on-air transmitter rf and clears rf_enable_request
// [RQ6] rf_disable_request or auto-rf request leaves maintenance, dummy-load rf_disable_request
// [RQ7] first-transmitter request makes it main and lights its indicator
// [RQ8] second-transmitter request makes it main and lights its indicator
// [RQ9] either transmitter request forces manual rf transfer and clears maintenance
// [RQ10] auto-rf request sets auto mode and routes main transmitter to antenna
// [RQ11] auto-audio request sets automatic audio transfer and lights indicator
// [RQ12] while auto-audio held, local and serial link audio commands ignored
// [RQ13] main-audio request selects main source and lights indicator
// [RQ14] backup-audio request selects backup source and lights indicator
// [RQ15] either audio source request forces manual audio transfer
// [RQ16] maintenance request enters maintenance, lights it, enables dummy-load rf
// [RQ17] maintenance request also cancels automatic rf transfer
// [RQ18] coax switch driven by two position lines, wanted one energized
// [RQ19] switch reports position on two contacts; device reads them as status
// [RQ20] switch opens interlock before moving, closes after transition completes
// [RQ21] two or more rf group requests at once: no action
// [RQ22] two or more audio group requests at once: no action
// [RQ23] rf_enable_request and rf_disable_request together: rf_disable_request wins
// [RQ24] rf held off while interlock open or position mismatches command
// [RQ25] inputs synchronised, debounced, accepted after stable low qualifying time
module rf_xfer_ctrl #(
  parameter int TICK_CYCLES = rf_xfer_pkg::TICK_CYCLES
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire rf_xfer_pkg::remote_n_t remote_n,
  input  wire rf_xfer_pkg::coax_in_t  coax_in,
  input  wire logic                  link_audio_valid,
  input  wire logic [1:0]            link_audio_cmd,
  output rf_xfer_pkg::coax_out_t     coax_out,
  output rf_xfer_pkg::rf_en_t        rf_en,
  output rf_xfer_pkg::status_t       status
);
  localparam logic [rf_xfer_pkg::TICK_W-1:0] TICK_LAST =
    rf_xfer_pkg::TICK_W'(TICK_CYCLES - 1);

  rf_xfer_pkg::state_t        st;
  rf_xfer_pkg::state_t        st_nxt;
  logic                       tick;
  logic [rf_xfer_pkg::N_IN-1:0] pulse;
  logic [rf_xfer_pkg::N_IN-1:0] acc;
  logic [2:0]                 rf_grp;
  logic [2:0]                 aud_grp;
  logic                       rf_ok;
  logic                       aud_ok;
  logic                       safe;
  logic                       local_valid;
  logic [1:0]                 local_cmd;
  logic                       audio_block;
  logic [31:0]                rd_word;

  // number of active levels in a group, at most four
  function automatic logic [2:0] ones4(input logic [3:0] v);
    ones4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
  endfunction

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      rf_xfer_pkg::CTRL_OFS:   rd_word[0] = st.remote_en;
      rf_xfer_pkg::QUAL_OFS:   rd_word[7:0] = st.qual;
      rf_xfer_pkg::STATUS_OFS: rd_word = {20'h0_0000, st.cflt, st.cmd_two, status};
      default:                 rd_word = 32'h0000_0000;
    endcase
  end

  // next state of the whole block
  always_comb begin
    st_nxt = st;
    // slow time base: one enable per millisecond
    tick = (st.tick_cnt == TICK_LAST);
    st_nxt.tick_cnt = tick ? '0 : st.tick_cnt + 1'b1;

    // three-stage synchronisers; the filter takes a value once stages two and three agree
    st_nxt.s1 = remote_n; // [RQ25]
    st_nxt.s2 = st.s1;
    st_nxt.s3 = st.s2;
    st_nxt.c1 = coax_in; // [RQ19]
    st_nxt.c2 = st.c1;
    st_nxt.c3 = st.c2;
    if (st.c2 == st.c3) begin
      st_nxt.cflt = st.c3;
    end
    for (int i = 0; i < rf_xfer_pkg::N_IN; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        st_nxt.flt[i] = st.s3[i];
      end
      // debounce: level counts as active only after qual ms stable low
      if (st.flt[i]) begin
        st_nxt.cnt[i] = 8'h00; // [RQ25]
        st_nxt.lvl[i] = 1'b0;
      end else if (st.cnt[i] >= st.qual) begin
        st_nxt.lvl[i] = 1'b1; // [RQ25]
      end else if (tick) begin
        st_nxt.cnt[i] = st.cnt[i] + 8'h01;
      end
    end

    // one action per accepted pulse, never on the held level
    pulse = st_nxt.lvl & ~st.lvl; // [RQ2]
    acc = pulse & {rf_xfer_pkg::N_IN{st.remote_en}}; // [RQ1]
    rf_grp = ones4({st_nxt.lvl[rf_xfer_pkg::I_TX1], st_nxt.lvl[rf_xfer_pkg::I_TX2],
                    st_nxt.lvl[rf_xfer_pkg::I_ARF], st_nxt.lvl[rf_xfer_pkg::I_MNT]});
    aud_grp = ones4({1'b0, st_nxt.lvl[rf_xfer_pkg::I_AAUD],
                     st_nxt.lvl[rf_xfer_pkg::I_MAUD], st_nxt.lvl[rf_xfer_pkg::I_BAUD]});
    rf_ok = (rf_grp < 3'h2); // [RQ21]
    aud_ok = (aud_grp < 3'h2); // [RQ22]

    // rf_enable_request/off, off has priority
    if (acc[rf_xfer_pkg::I_OFF]) begin
      st_nxt.rf_enable_request = 1'b0; // [RQ5] [RQ23]
      st_nxt.maint = 1'b0; // [RQ6]
    end else if (acc[rf_xfer_pkg::I_ON]) begin
      st_nxt.rf_enable_request = 1'b1; // [RQ4]
    end

    // rf transfer group
    if (rf_ok) begin
      if (acc[rf_xfer_pkg::I_TX1]) begin
        st_nxt.main_two = 1'b0; // [RQ7]
        st_nxt.cmd_two = 1'b0;
        st_nxt.auto_rf = 1'b0; // [RQ9]
        st_nxt.maint = 1'b0;
      end
      if (acc[rf_xfer_pkg::I_TX2]) begin
        st_nxt.main_two = 1'b1; // [RQ8]
        st_nxt.cmd_two = 1'b1;
        st_nxt.auto_rf = 1'b0; // [RQ9]
        st_nxt.maint = 1'b0;
      end
      if (acc[rf_xfer_pkg::I_ARF]) begin
        st_nxt.auto_rf = 1'b1; // [RQ10]
        st_nxt.cmd_two = st.main_two;
        st_nxt.maint = 1'b0; // [RQ6]
      end
      if (acc[rf_xfer_pkg::I_MNT]) begin
        st_nxt.maint = 1'b1; // [RQ16]
        st_nxt.auto_rf = 1'b0; // [RQ17]
      end
    end

    // local audio commands come first so a remote pulse in the same cycle overrides
    audio_block = st.remote_en & st.lvl[rf_xfer_pkg::I_AAUD];
    local_valid = (st.a_valid & st.a_write & (st.a_addr == rf_xfer_pkg::AUDIO_CMD_OFS))
                  | link_audio_valid;
    local_cmd = link_audio_valid ? link_audio_cmd : hwdata[1:0];
    if (local_valid && !audio_block) begin // [RQ12]
      case (local_cmd)
        rf_xfer_pkg::ACMD_AUTO:   st_nxt.auto_audio = 1'b1;
        rf_xfer_pkg::ACMD_MAIN: begin
          st_nxt.audio_backup = 1'b0;
          st_nxt.auto_audio = 1'b0;
        end
        rf_xfer_pkg::ACMD_BACKUP: begin
          st_nxt.audio_backup = 1'b1;
          st_nxt.auto_audio = 1'b0;
        end
        default: st_nxt.auto_audio = st.auto_audio;
      endcase
    end

    // audio transfer group
    if (aud_ok) begin
      if (acc[rf_xfer_pkg::I_AAUD]) begin
        st_nxt.auto_audio = 1'b1; // [RQ11]
      end
      if (acc[rf_xfer_pkg::I_MAUD]) begin
        st_nxt.audio_backup = 1'b0; // [RQ13]
        st_nxt.auto_audio = 1'b0; // [RQ15]
      end
      if (acc[rf_xfer_pkg::I_BAUD]) begin
        st_nxt.audio_backup = 1'b1; // [RQ14]
        st_nxt.auto_audio = 1'b0; // [RQ15]
      end
    end

    // rf only while the switch sits where commanded with its interlock made;
    // the switch opens the interlock before it moves, so this also covers transit
    safe = st.cflt[2] & (st.cflt[0] == !st.cmd_two) & (st.cflt[1] == st.cmd_two); // [RQ20]
    st_nxt.rf1 = safe & ((st.rf_enable_request & !st.cmd_two) | (st.maint & st.cmd_two)); // [RQ24]
    st_nxt.rf2 = safe & ((st.rf_enable_request & st.cmd_two) | (st.maint & !st.cmd_two)); // [RQ24]

    // ahb-lite: register the address phase, write in the data phase
    st_nxt.a_valid = hsel & htrans[1] & hready;
    if (hsel && htrans[1] && hready) begin
      st_nxt.a_write = hwrite;
      st_nxt.a_addr = haddr[7:0];
      if (!hwrite) begin
        st_nxt.hrdata = rd_word;
      end
    end
    if (st.a_valid && st.a_write) begin
      case (st.a_addr)
        rf_xfer_pkg::CTRL_OFS: st_nxt.remote_en = hwdata[rf_xfer_pkg::CTRL_REMOTE_BIT];
        rf_xfer_pkg::QUAL_OFS: st_nxt.qual = hwdata[7:0];
        default:               st_nxt.remote_en = st.remote_en;
      endcase
    end
  end

  // state register; remote input stages reset to their idle high level, coax contact stages to zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.s1 <= '1;
      st.s2 <= '1;
      st.s3 <= '1;
      st.flt <= '1;
      st.qual <= rf_xfer_pkg::QUAL_MS_RST;
    end else begin
      st <= st_nxt;
    end
  end

  // outputs straight from flops; zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.hrdata;
  assign coax_out.pos_one_drive = !st.cmd_two; // [RQ18]
  assign coax_out.pos_two_drive = st.cmd_two; // [RQ18]
  assign rf_en.first_transmitter_rf_en = st.rf1;
  assign rf_en.second_transmitter_rf_en = st.rf2;
  assign status = {st.remote_en, st.maint, st.audio_backup, st.auto_audio, st.auto_rf,
                   st.main_two, !st.main_two, st.rf_enable_request};

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_remote_gate: assert property (!st.remote_en |=> $stable(st.rf_enable_request) && $stable(st.maint)) // [RQ1]
    else $error("rf state changed while remote disabled");
  a_pulse_once: assert property (pulse[rf_xfer_pkg::I_ON] |=> !pulse[rf_xfer_pkg::I_ON]) // [RQ2]
    else $error("pulse lasted more than one cycle");
  a_rf_enable_request_set: assert property (acc[rf_xfer_pkg::I_ON] && !acc[rf_xfer_pkg::I_OFF] // [RQ4]
    |=> st.rf_enable_request)
    else $error("rf_enable_request pulse did not set rf_enable_request");
  // a maintenance pulse in the same cycle as rf_disable_request re-enters maintenance, as the logic orders it
  a_rf_disable_request_wins: assert property (acc[rf_xfer_pkg::I_OFF] // [RQ23]
    && !(rf_ok && acc[rf_xfer_pkg::I_MNT]) |=> !st.rf_enable_request && !st.maint)
    else $error("rf_disable_request pulse did not clear rf and maintenance");
  a_tx_select: assert property (rf_ok && acc[rf_xfer_pkg::I_TX2] // [RQ9]
    |=> st.main_two && st.cmd_two && !st.auto_rf && !st.maint)
    else $error("second transmitter selection wrong");
  a_auto_route: assert property (rf_ok && acc[rf_xfer_pkg::I_ARF] // [RQ10]
    |=> st.auto_rf && (st.cmd_two == $past(st.main_two)))
    else $error("auto rf did not route main transmitter");
  a_maint_enter: assert property (rf_ok && acc[rf_xfer_pkg::I_MNT] // [RQ17]
    && !acc[rf_xfer_pkg::I_OFF] |=> st.maint && !st.auto_rf)
    else $error("maintenance entry wrong");
  a_rf_conflict: assert property (!rf_ok && !acc[rf_xfer_pkg::I_OFF] // [RQ21]
    |=> $stable(st.cmd_two) && $stable(st.maint) && $stable(st.auto_rf))
    else $error("rf group conflict acted");
  a_audio_src: assert property (aud_ok && acc[rf_xfer_pkg::I_BAUD] // [RQ15]
    |=> st.audio_backup && !st.auto_audio)
    else $error("backup audio selection wrong");
  a_audio_block: assert property (audio_block && !acc[rf_xfer_pkg::I_MAUD] // [RQ12]
    && !acc[rf_xfer_pkg::I_BAUD] |=> $stable(st.audio_backup))
    else $error("audio source changed while auto held");
  a_rf_safe: assert property ((st.rf1 || st.rf2) |-> $past(st.cflt[2])) // [RQ24]
    else $error("rf enabled with interlock open");
  a_drive_excl: assert property (coax_out.pos_one_drive != coax_out.pos_two_drive) // [RQ18]
    else $error("coax drive lines both equal");
  a_qual_low: assert property (pulse[rf_xfer_pkg::I_TX1] |-> !st.flt[rf_xfer_pkg::I_TX1]) // [RQ25]
    else $error("pulse accepted without stable low input");

  c_rf_enable_request: cover property (acc[rf_xfer_pkg::I_ON] ##1 st.rf1);
  c_maint: cover property (acc[rf_xfer_pkg::I_MNT] ##[1:50] (st.rf1 || st.rf2));
  c_conflict: cover property (!rf_ok && pulse[rf_xfer_pkg::I_TX1]);
  c_audio_block: cover property (audio_block && local_valid);
endmodule

// [dv/coax_switch_model.sv]
// model of the external two-position coax transfer switch with aux contacts and interlock
// assumes the drive lines are sampled on the bench clock and one move runs at a time
module coax_switch_model #(
  parameter int MOVE_CYCLES = 30
) (
  input  wire logic                   clk,
  input  wire logic                   slow,
  input  wire rf_xfer_pkg::coax_out_t drive,
  output rf_xfer_pkg::coax_in_t       contacts = 3'h5
);
  timeunit 1ns;
  timeprecision 1ps;

  logic pos_r = 1'b0;
  logic tgt_r = 1'b0;
  int   cnt_r = 0;
  int   span;

  // a slow switch takes three times as long to reach its new position
  assign span = slow ? 3 * MOVE_CYCLES : MOVE_CYCLES;

  // both or neither line energized is no valid command, so the switch stays put
  always @(posedge clk) begin
    if (cnt_r == 0) begin
      if (drive.pos_one_drive != drive.pos_two_drive && drive.pos_two_drive != pos_r) begin
        tgt_r <= drive.pos_two_drive;
        contacts.interlock_closed <= 1'b0;
        cnt_r <= 1;
      end
    end else begin
      cnt_r <= cnt_r + 1;
      // aux contacts are open while the rotor travels
      if (cnt_r == 2) begin
        contacts.switch_indicates_position_one <= 1'b0;
        contacts.switch_indicates_position_two <= 1'b0;
      end
      if (cnt_r == span) begin
        pos_r <= tgt_r;
        contacts.switch_indicates_position_one <= !tgt_r;
        contacts.switch_indicates_position_two <= tgt_r;
      end
      if (cnt_r == span + 2) begin
        contacts.interlock_closed <= 1'b1;
        cnt_r <= 0;
      end
    end
  end
endmodule

// [dv/testbench.sv]
// self-checking bench for the transfer control block: ahb master, remote pulses, coax partner
// assumes the switch model answers the coax drive; a bit-level state model predicts outputs
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TICKS = 10; // one qualifying tick, shortened from a millisecond

  logic                   hclk     = 1'b0;
  logic                   hresetn  = 1'b0;
  logic                   hsel     = 1'b0;
  logic [31:0]            haddr    = 32'h0;
  logic [1:0]             htrans   = 2'h0;
  logic                   hwrite   = 1'b0;
  logic [2:0]             hsize    = 3'h2;
  logic [31:0]            hwdata   = 32'h0;
  logic                   hreadyout;
  logic                   hresp;
  logic [31:0]            hrdata;
  rf_xfer_pkg::remote_n_t remote_n = 9'h1FF;
  rf_xfer_pkg::coax_in_t  coax_in;
  logic                   link_audio_valid = 1'b0;
  logic [1:0]             link_audio_cmd   = 2'h0;
  rf_xfer_pkg::coax_out_t coax_out;
  rf_xfer_pkg::rf_en_t    rf_en;
  rf_xfer_pkg::status_t   status;
  logic                   slow     = 1'b0;
  logic [31:0]            rd;
  logic [31:0]            r;
  logic [31:0]            seed     = 32'h92FE75CB;
  int                     failures = 0;
  int                     samples_checked = 0;
  bit                     m_rem, m_on, m_two, m_arf, m_aaud, m_bak, m_mnt;

  always #4 hclk = ~hclk;

  rf_xfer_ctrl #(.TICK_CYCLES(TICKS)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .remote_n(remote_n),
    .coax_in(coax_in), .link_audio_valid(link_audio_valid), .link_audio_cmd(link_audio_cmd),
    .coax_out(coax_out), .rf_en(rf_en), .status(status)
  );

  coax_switch_model #(.MOVE_CYCLES(30)) coax_sw (
    .clk(hclk), .slow(slow), .drive(coax_out), .contacts(coax_in)
  );

  task automatic test_done;
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // single word transfer; address phase held until hready, read data taken at data end
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  function automatic logic [7:0] st_exp();
    return {m_rem, m_mnt, m_bak, m_aaud, m_arf, m_two, !m_two, m_on};
  endfunction

  // reference model of one accepted remote pulse, conflicts included
  function automatic void apply(input logic [8:0] m);
    if (!m_rem) return;
    if (m[rf_xfer_pkg::I_OFF]) m_mnt = 1'b0;
    if (m[rf_xfer_pkg::I_OFF] || m[rf_xfer_pkg::I_ON]) m_on = !m[rf_xfer_pkg::I_OFF];
    if ($countones(m & 9'h11C) == 1) begin
      if (!m[rf_xfer_pkg::I_ARF] && !m[rf_xfer_pkg::I_MNT]) m_two = m[rf_xfer_pkg::I_TX2];
      m_arf = m[rf_xfer_pkg::I_ARF];
      m_mnt = m[rf_xfer_pkg::I_MNT];
    end
    if ($countones(m & 9'h0E0) == 1) begin
      if (!m[rf_xfer_pkg::I_AAUD]) m_bak = m[rf_xfer_pkg::I_BAUD];
      m_aaud = m[rf_xfer_pkg::I_AAUD];
    end
  endfunction

  function automatic void audio_cmd(input logic [1:0] c);
    if (c != rf_xfer_pkg::ACMD_AUTO) m_bak = (c == rf_xfer_pkg::ACMD_BACKUP);
    m_aaud = (c == rf_xfer_pkg::ACMD_AUTO);
  endfunction

  task automatic check_all;
    chk("status", status, st_exp());
    chk("coax_out", coax_out, {m_two, !m_two});
    chk("rf_en", rf_en, m_two ? {m_on, m_mnt} : {m_mnt, m_on});
  endtask

  // wait for the switch to land where the model says, then for the resync of rf_en
  task automatic settle;
    repeat (5) @(posedge hclk);
    while (!(coax_in.interlock_closed && coax_in.switch_indicates_position_two == m_two
             && coax_in.switch_indicates_position_one != m_two)) @(posedge hclk);
    repeat (8) @(posedge hclk);
  endtask

  task automatic pulse(input logic [8:0] m, input bit probe);
    remote_n <= rf_xfer_pkg::remote_n_t'(~m);
    if (probe) begin
      while (coax_in.interlock_closed) @(posedge hclk);
      repeat (8) @(posedge hclk);
      chk("rf_en_moving", rf_en, 32'h0);
    end else repeat (50) @(posedge hclk);
    remote_n <= 9'h1FF;
    apply(m);
    settle();
    check_all();
  endtask

  task automatic link(input logic [1:0] c);
    link_audio_valid <= 1'b1;
    link_audio_cmd   <= c;
    @(posedge hclk);
    link_audio_valid <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask

  // hang guard, far beyond the few thousand cycles the sequence needs
  initial begin
    repeat (40000) @(posedge hclk);
    failures++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_all();
    bus(1'b0, rf_xfer_pkg::CTRL_OFS, 32'h0);
    chk("ctrl", rd, 32'h0);
    bus(1'b0, rf_xfer_pkg::QUAL_OFS, 32'h0);
    chk("qual", rd, {24'h0, rf_xfer_pkg::QUAL_MS_RST});
    // shorten qualification first, so the pulse below does qualify and only the gate stops it
    bus(1'b1, rf_xfer_pkg::QUAL_OFS, 32'h2);
    pulse(9'h001, 1'b0);
    bus(1'b1, rf_xfer_pkg::CTRL_OFS, 32'h1);
    bus(1'b0, rf_xfer_pkg::QUAL_OFS, 32'h0);
    chk("qual", rd, 32'h2);
    m_rem = 1'b1;
    for (int i = 0; i < 9; i++) pulse(9'h1 << i, 1'b0);
    pulse(9'h002, 1'b0);
    pulse(9'h100, 1'b0);
    pulse(9'h010, 1'b0);
    pulse(9'h001, 1'b0);
    pulse(9'h003, 1'b0);
    pulse(9'h00C, 1'b0);
    pulse(9'h104, 1'b0);
    pulse(9'h0C0, 1'b0);
    pulse(9'h001, 1'b0);
    slow <= 1'b1;
    pulse(9'h004, 1'b1);
    slow <= 1'b0;
    // hold the auto audio input: local and link audio commands must be ignored
    remote_n <= rf_xfer_pkg::remote_n_t'(~9'h020);
    repeat (50) @(posedge hclk);
    apply(9'h020);
    bus(1'b1, rf_xfer_pkg::AUDIO_CMD_OFS, {30'h0, rf_xfer_pkg::ACMD_MAIN});
    link(rf_xfer_pkg::ACMD_MAIN);
    check_all();
    remote_n <= 9'h1FF;
    repeat (20) @(posedge hclk);
    link(rf_xfer_pkg::ACMD_MAIN);
    audio_cmd(rf_xfer_pkg::ACMD_MAIN);
    check_all();
    for (int c = 1; c < 4; c++) begin
      bus(1'b1, rf_xfer_pkg::AUDIO_CMD_OFS, 32'(c));
      repeat (3) @(posedge hclk);
      audio_cmd(2'(c));
      check_all();
    end
    repeat (12) begin
      r = $random(seed);
      pulse((9'h1 << (r[7:0] % 9)) | (r[16] ? 9'h1 << (r[15:8] % 9) : 9'h0),
            1'b0);
    end
    bus(1'b1, rf_xfer_pkg::STATUS_OFS, 32'hFF);
    bus(1'b1, 8'h10, 32'hFFFF);
    bus(1'b0, rf_xfer_pkg::STATUS_OFS, 32'h0);
    // settled switch: interlock made, indication matching the commanded position
    chk("status_reg", rd, {20'h0, 1'b1, m_two, !m_two, m_two, st_exp()});
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(1'b1, rf_xfer_pkg::CTRL_OFS, 32'h0);
    m_rem = 1'b0;
    // ask for the other transmitter: any leak through the gate would move the switch
    pulse(m_two ? 9'h004 : 9'h008, 1'b0);
    test_done();
  end
endmodule
